//--- rtl/accel_control_register_map.sv
// register bank of the accelerometer: control, status, samples and boot trim restore
`timescale 1ns/1ps
module accel_control_register_map
    import accel_regs_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire reg_req_t    i_req,
    output logic [7:0]       o_rdata,
    output logic             o_rvalid,
    input  wire logic        i_sample_strobe,
    input  wire sample_t     i_sample,
    input  wire logic [7:0]  i_ev1_source,
    input  wire logic [7:0]  i_ev2_source,
    input  wire logic [7:0]  i_trim_rom [TRIM_N],
    output logic [7:0]       o_trim [TRIM_N],
    output ctrl1_t           o_ctrl1,
    output ctrl2_t           o_ctrl2,
    output logic [7:0]       o_pad_ctrl,
    output logic [7:0]       o_ev_cfg [2],
    output logic [7:0]       o_ev_ths [2],
    output logic [7:0]       o_ev_dur [2],
    output logic             o_hp_filter_clear,
    output logic             o_ev1_ack,
    output logic             o_ev2_ack,
    output logic             o_sample_ready,
    output logic             o_data_on_shared_pin,
    output logic             o_boot_busy
);

    typedef struct packed {
        ctrl1_t       ctrl1;
        ctrl2_t       ctrl2;
        logic [7:0]   pad_ctrl;
        logic [7:0]   ev1_cfg;
        logic [7:0]   ev1_ths;
        logic [7:0]   ev1_dur;
        logic [7:0]   ev2_cfg;
        logic [7:0]   ev2_ths;
        logic [7:0]   ev2_dur;
        status_t      status;
        sample_t      sample;
        logic [7:0]   rdata;
        logic         rvalid;
        logic         hp_clear;
        logic         ack1;
        logic         ack2;
        logic         ready;
        boot_state_t  boot;
        logic [1:0]   trim_idx;
        logic [TRIM_N*DATA_W-1:0] trim;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    always_comb begin
        logic [7:0] rd;
        status_t    st;
        rd = RST_ZERO;
        st = state_r.status;
        state_nxt = state_r;
        state_nxt.rvalid = 1'b0;
        state_nxt.hp_clear = 1'b0;
        state_nxt.ack1 = 1'b0;
        state_nxt.ack2 = 1'b0;
        state_nxt.ready = 1'b0;

        // reading clears flags; a new sample in the same cycle sets them again below
        if (i_req.rd) begin
            unique case (i_req.addr)
                ADDR_IDENTITY: rd = IDENTITY_VALUE;
                ADDR_CTRL1:    rd = state_r.ctrl1;
                ADDR_CTRL2:    rd = state_r.ctrl2;
                ADDR_PAD_CTRL: rd = state_r.pad_ctrl;
                ADDR_HP_RESET: state_nxt.hp_clear = 1'b1;
                ADDR_STATUS:   begin
                    rd = state_r.status;
                    st = RST_ZERO;
                end
                ADDR_X: begin
                    rd = state_r.sample.x;
                    st.x_ready = 1'b0;
                    st.x_overrun = 1'b0;
                end
                ADDR_Y: begin
                    rd = state_r.sample.y;
                    st.y_ready = 1'b0;
                    st.y_overrun = 1'b0;
                end
                ADDR_Z: begin
                    rd = state_r.sample.z;
                    st.z_ready = 1'b0;
                    st.z_overrun = 1'b0;
                end
                ADDR_EV1_CFG:  rd = state_r.ev1_cfg;
                ADDR_EV1_SRC:  begin
                    rd = i_ev1_source;
                    state_nxt.ack1 = 1'b1;
                end
                ADDR_EV1_THS:  rd = state_r.ev1_ths;
                ADDR_EV1_DUR:  rd = state_r.ev1_dur;
                ADDR_EV2_CFG:  rd = state_r.ev2_cfg;
                ADDR_EV2_SRC:  begin
                    rd = i_ev2_source;
                    state_nxt.ack2 = 1'b1;
                end
                ADDR_EV2_THS:  rd = state_r.ev2_ths;
                ADDR_EV2_DUR:  rd = state_r.ev2_dur;
                default:       rd = RST_ZERO;
            endcase
            state_nxt.rdata = rd;
            state_nxt.rvalid = 1'b1;
        end

        // sample arrival while powered: all axes stored, flags for enabled axes only; overrun if previous unread, set beats clear
        if (i_sample_strobe && state_r.ctrl1.power_active) begin
            state_nxt.sample = i_sample;
            if (state_r.ctrl1.axis_x_enable) begin
                st.x_overrun = st.x_overrun | state_r.status.x_ready;
                st.x_ready = 1'b1;
            end
            if (state_r.ctrl1.axis_y_enable) begin
                st.y_overrun = st.y_overrun | state_r.status.y_ready;
                st.y_ready = 1'b1;
            end
            if (state_r.ctrl1.axis_z_enable) begin
                st.z_overrun = st.z_overrun | state_r.status.z_ready;
                st.z_ready = 1'b1;
            end
            state_nxt.ready = |{state_r.ctrl1.axis_x_enable, state_r.ctrl1.axis_y_enable,
                                state_r.ctrl1.axis_z_enable};
        end
        st.zyx_ready = st.x_ready | st.y_ready | st.z_ready;
        st.zyx_overrun = st.x_overrun | st.y_overrun | st.z_overrun;
        state_nxt.status = st;

        // writes land only on read-write addresses; reserved and read-only are dropped
        if (i_req.wr && is_writable(i_req.addr)) begin
            unique case (i_req.addr)
                ADDR_CTRL1:    state_nxt.ctrl1 = i_req.wdata;
                ADDR_CTRL2:    state_nxt.ctrl2 = i_req.wdata;
                ADDR_PAD_CTRL: state_nxt.pad_ctrl = i_req.wdata;
                ADDR_EV1_CFG:  state_nxt.ev1_cfg = i_req.wdata;
                ADDR_EV1_THS:  state_nxt.ev1_ths = i_req.wdata;
                ADDR_EV1_DUR:  state_nxt.ev1_dur = i_req.wdata;
                ADDR_EV2_CFG:  state_nxt.ev2_cfg = i_req.wdata;
                ADDR_EV2_THS:  state_nxt.ev2_ths = i_req.wdata;
                default:       state_nxt.ev2_dur = i_req.wdata;
            endcase
        end

        // trim copy, one word per cycle; a boot in progress keeps reboot set
        unique case (state_r.boot)
            BOOT_IDLE: begin
                if (state_r.ctrl2.reboot) begin
                    state_nxt.boot = BOOT_COPY;
                    state_nxt.trim_idx = '0;
                end
            end
            BOOT_COPY: begin
                state_nxt.trim[state_r.trim_idx*DATA_W +: DATA_W] = i_trim_rom[state_r.trim_idx];
                state_nxt.trim_idx = state_r.trim_idx + 2'd1;
                state_nxt.ctrl2.reboot = 1'b1;
                if (state_r.trim_idx == 2'(TRIM_N - 1)) begin
                    state_nxt.boot = BOOT_DONE;
                end
            end
            BOOT_DONE: begin
                state_nxt.ctrl2.reboot = 1'b0;
                state_nxt.boot = BOOT_IDLE;
            end
            default: state_nxt.boot = BOOT_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_nxt_apply_reset: begin
                state_r <= '0;
                state_r.ctrl1 <= RST_CTRL1;
                // power-up restores trims by starting a boot copy
                state_r.ctrl2.reboot <= 1'b1;
                state_r.boot <= BOOT_IDLE;
            end
        end else begin
            state_r <= state_nxt;
        end
    end

    always_comb begin
        for (int i = 0; i < TRIM_N; i++) begin
            o_trim[i] = state_r.trim[i*DATA_W +: DATA_W];
        end
    end

    assign o_rdata              = state_r.rdata;
    assign o_rvalid             = state_r.rvalid;
    assign o_ctrl1              = state_r.ctrl1;
    assign o_ctrl2              = state_r.ctrl2;
    assign o_pad_ctrl           = state_r.pad_ctrl;
    assign o_ev_cfg[0]          = state_r.ev1_cfg;
    assign o_ev_cfg[1]          = state_r.ev2_cfg;
    assign o_ev_ths[0]          = state_r.ev1_ths;
    assign o_ev_ths[1]          = state_r.ev2_ths;
    assign o_ev_dur[0]          = state_r.ev1_dur;
    assign o_ev_dur[1]          = state_r.ev2_dur;
    assign o_hp_filter_clear    = state_r.hp_clear;
    assign o_ev1_ack            = state_r.ack1;
    assign o_ev2_ack            = state_r.ack2;
    assign o_sample_ready       = state_r.ready;
    assign o_data_on_shared_pin = state_r.ctrl2.three_wire_select;
    assign o_boot_busy          = state_r.ctrl2.reboot;

endmodule

//--- rtl/accel_regs_pkg.sv
// constants, register layout and carrier types of the accelerometer control register bank
// Functional notes
// - every register is 8 bits; each address is read-write, read-only or reserved.
// - a 7-bit address from the serial command selects registers for reads and writes.
// - identity register at 0x0f always returns a fixed 8-bit identifier.
// - factory calibration reloads at power-up; host should not alter boot-loaded registers.
// - rate_select 0 gives 100 Hz sample rate, 1 gives 400 Hz.
// - power_active 0 holds power-down (reset), 1 enters active measurement.
// - range_select chooses between two full-scale ranges, resets to 0.
// - either self-test bit applies stimulus; clearing both returns to normal measurement.
// - per-axis enables gate sample_ready for their axis; all reset to 1.
// - three_wire_select 0 sends read data on serial_out_pin, 1 on shared_data_pin.
// - writing reboot 1 copies factory trims into trimming registers, then self-clears.
// - filtered_output_select 1 feeds high-pass data to outputs; 0 bypasses filter.
// - hp_event1/2_enable route filtered data to their event generator; 0 bypasses.
// - hp_cutoff_select codes 00..11 halve cut-off: 2..0.25 Hz or 8..1 Hz.
// - reading the filter-reset address zeroes filter state; read data is meaningless.
// - status sets per-axis and combined data-available and overrun flags.
package accel_regs_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int TRIM_N = 4;

    localparam logic [6:0] ADDR_IDENTITY  = 7'h0f;
    localparam logic [6:0] ADDR_CTRL1     = 7'h20;
    localparam logic [6:0] ADDR_CTRL2     = 7'h21;
    localparam logic [6:0] ADDR_PAD_CTRL  = 7'h22;
    localparam logic [6:0] ADDR_HP_RESET  = 7'h23;
    localparam logic [6:0] ADDR_STATUS    = 7'h27;
    localparam logic [6:0] ADDR_X         = 7'h29;
    localparam logic [6:0] ADDR_Y         = 7'h2b;
    localparam logic [6:0] ADDR_Z         = 7'h2d;
    localparam logic [6:0] ADDR_EV1_CFG   = 7'h30;
    localparam logic [6:0] ADDR_EV1_SRC   = 7'h31;
    localparam logic [6:0] ADDR_EV1_THS   = 7'h32;
    localparam logic [6:0] ADDR_EV1_DUR   = 7'h33;
    localparam logic [6:0] ADDR_EV2_CFG   = 7'h34;
    localparam logic [6:0] ADDR_EV2_SRC   = 7'h35;
    localparam logic [6:0] ADDR_EV2_THS   = 7'h36;
    localparam logic [6:0] ADDR_EV2_DUR   = 7'h37;

    localparam logic [7:0] RST_CTRL1 = 8'h07;
    localparam logic [7:0] RST_ZERO  = 8'h00;

    // identifier value is arbitrary
    localparam logic [7:0] IDENTITY_VALUE = 8'h5a;

    localparam real HP_CUTOFF_HZ_100 = 2.0;
    localparam real HP_CUTOFF_HZ_400 = 8.0;

    typedef struct packed {
        logic       rate_select;
        logic       power_active;
        logic       range_select;
        logic       self_test_plus;
        logic       self_test_minus;
        logic       axis_z_enable;
        logic       axis_y_enable;
        logic       axis_x_enable;
    } ctrl1_t;

    typedef struct packed {
        logic       three_wire_select;
        logic       reboot;
        logic       filtered_output_select;
        logic       hp_event2_enable;
        logic       hp_event1_enable;
        logic       unused2;
        logic [1:0] hp_cutoff_select;
    } ctrl2_t;

    typedef struct packed {
        logic       zyx_overrun;
        logic       z_overrun;
        logic       y_overrun;
        logic       x_overrun;
        logic       zyx_ready;
        logic       z_ready;
        logic       y_ready;
        logic       x_ready;
    } status_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] x;
        logic [7:0] y;
        logic [7:0] z;
    } sample_t;

    typedef enum logic [2:0] {
        BOOT_IDLE = 3'b001,
        BOOT_COPY = 3'b010,
        BOOT_DONE = 3'b100
    } boot_state_t;

    function automatic logic is_writable(input logic [6:0] a);
        is_writable = (a == ADDR_CTRL1) || (a == ADDR_CTRL2) || (a == ADDR_PAD_CTRL)
                   || (a == ADDR_EV1_CFG) || (a == ADDR_EV1_THS) || (a == ADDR_EV1_DUR)
                   || (a == ADDR_EV2_CFG) || (a == ADDR_EV2_THS) || (a == ADDR_EV2_DUR);
    endfunction

endpackage

//--- test/accel_regs_monitor.sv
// port assertions for the accelerometer register bank
`timescale 1ns/1ps
module accel_regs_monitor
    import accel_regs_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_srst,
    input wire reg_req_t   i_req,
    input wire logic [7:0] o_rdata,
    input wire logic       o_rvalid,
    input wire logic       i_sample_strobe,
    input wire ctrl1_t     o_ctrl1,
    input wire ctrl2_t     o_ctrl2,
    input wire logic       o_hp_filter_clear,
    input wire logic       o_sample_ready,
    input wire logic       o_data_on_shared_pin,
    input wire logic       o_boot_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    wire logic rd_at_id = i_req.rd && i_req.addr == ADDR_IDENTITY;
    wire logic wr_c1    = i_req.wr && i_req.addr == ADDR_CTRL1;
    wire logic wr_c2    = i_req.wr && i_req.addr == ADDR_CTRL2;

    a_read_answer: assert property (i_req.rd |=> o_rvalid)
        else $error("read not answered");
    a_no_stray_rvalid: assert property (!i_req.rd |=> !o_rvalid)
        else $error("rvalid without read");
    a_identity_value: assert property (rd_at_id |=> o_rdata == IDENTITY_VALUE)
        else $error("identity value wrong");
    a_ctrl1_write: assert property (wr_c1 |=> o_ctrl1 == $past(i_req.wdata))
        else $error("control write lost");
    a_ro_write_kept: assert property (!o_boot_busy && i_req.wr && i_req.addr == ADDR_STATUS
        |=> $stable(o_ctrl1) && $stable(o_ctrl2))
        else $error("read-only write changed state");
    a_wire_mode: assert property (wr_c2 |=> o_data_on_shared_pin == $past(i_req.wdata[7]))
        else $error("data pin select wrong");
    a_boot_ends: assert property ($rose(o_boot_busy) |-> o_boot_busy[*4] ##[1:4] !o_boot_busy)
        else $error("reboot bit did not clear");
    a_filter_clear: assert property (i_req.rd && i_req.addr == ADDR_HP_RESET
        |=> o_hp_filter_clear)
        else $error("filter clear missing");
    a_powerdown_quiet: assert property (i_sample_strobe && !o_ctrl1.power_active
        |=> !o_sample_ready)
        else $error("ready while powered down");
    a_axis_ready: assert property (i_sample_strobe && o_ctrl1.power_active && o_ctrl1[2:0] != 3'h0
        |=> o_sample_ready)
        else $error("ready missing");
    a_reset_values: assert property ($fell(i_srst) |-> o_ctrl1 == RST_CTRL1
        && o_ctrl2.hp_cutoff_select == 2'h0)
        else $error("reset value wrong");
    c_id_read: cover property (rd_at_id ##1 o_rvalid);
    c_reboot: cover property ($rose(o_boot_busy));
    c_ready: cover property (o_sample_ready);
endmodule
bind accel_control_register_map accel_regs_monitor u_accel_regs_monitor (.i_clk(i_clk),
    .i_srst(i_srst), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_sample_strobe(i_sample_strobe), .o_ctrl1(o_ctrl1), .o_ctrl2(o_ctrl2),
    .o_hp_filter_clear(o_hp_filter_clear), .o_sample_ready(o_sample_ready),
    .o_data_on_shared_pin(o_data_on_shared_pin), .o_boot_busy(o_boot_busy));

//--- test/host_bfm.sv
// host side model: issues single-byte register requests like the serial front end
`timescale 1ns/1ps
module host_bfm
    import accel_regs_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    output reg_req_t        o_req
);
    initial o_req = '0;
    // a write into a reserved range may damage the part, so the host drops it
    function automatic logic is_reserved(input logic [6:0] a);
        return (a < 7'h20 && a != 7'h0f) || (a inside {[7'h24:7'h26], 7'h2e, 7'h2f}) || a > 7'h37;
    endfunction
    // idle bus shows inverted values, never the last request
    task automatic idle();
        @(posedge i_clk);
        o_req <= '{1'b0, 1'b0, ~o_req.addr, ~o_req.wdata};
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        if (is_reserved(a)) return;
        @(posedge i_clk);
        o_req <= '{1'b1, 1'b0, a, d};
        idle();
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_req <= '{1'b0, 1'b1, a, ~o_req.wdata};
        idle();
        d = i_rvalid ? i_rdata : 8'hxx;
    endtask
endmodule

//--- test/tb_top.sv
// self-checking bench for the accelerometer register bank
`timescale 1ns/1ps
module tb_top
    import accel_regs_pkg::*;
;
    logic       clk = 1'b0, srst = 1'b1, strobe = 1'b0, rvalid, hpc, ack1, ack2, srdy, shared;
    logic       busy, r;
    logic [7:0] rdata, pad, d;
    logic [7:0] rom [TRIM_N], trim [TRIM_N], evc [2], evt [2], evd [2];
    reg_req_t   req;
    sample_t    sample = '0;
    ctrl1_t     c1;
    ctrl2_t     c2;
    int         error_cnt = 0, cmp_count = 0;
    logic [6:0] rw_a [9] = '{ADDR_CTRL1, ADDR_CTRL2, ADDR_PAD_CTRL, ADDR_EV1_CFG, ADDR_EV1_THS,
                             ADDR_EV1_DUR, ADDR_EV2_CFG, ADDR_EV2_THS, ADDR_EV2_DUR};
    always #5 clk = ~clk;
    host_bfm u_host_bfm (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
    accel_control_register_map u_accel_control_register_map (.i_clk(clk), .i_srst(srst),
        .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid), .i_sample_strobe(strobe),
        .i_sample(sample), .i_ev1_source(8'h3c), .i_ev2_source(8'hc3), .i_trim_rom(rom),
        .o_trim(trim), .o_ctrl1(c1), .o_ctrl2(c2), .o_pad_ctrl(pad), .o_ev_cfg(evc),
        .o_ev_ths(evt), .o_ev_dur(evd), .o_hp_filter_clear(hpc), .o_ev1_ack(ack1),
        .o_ev2_ack(ack2), .o_sample_ready(srdy), .o_data_on_shared_pin(shared), .o_boot_busy(busy));
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %0t byte %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %0t bit %b expected %b", $time, g, e);
        end
    endtask
    task automatic rx(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_host_bfm.rd(a, v);
        chk8(v, e);
    endtask
    task automatic samp(input sample_t s, output logic rdy);
        @(posedge clk);
        strobe <= 1'b1;
        sample <= s;
        @(posedge clk);
        strobe <= 1'b0;
        sample <= ~s;
        #1 rdy = srdy;
    endtask
    task automatic wait_boot();
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk);
        chk1(busy, 1'b0);
    endtask
    task automatic test_done();
        if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
    initial begin
        rom = '{8'h11, 8'h22, 8'h33, 8'h44};
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        wait_boot();
        for (int i = 0; i < TRIM_N; i++) chk8(trim[i], rom[i]);
        rx(ADDR_IDENTITY, IDENTITY_VALUE);
        rx(ADDR_CTRL1, RST_CTRL1);
        rx(ADDR_CTRL2, RST_ZERO);
        for (int i = 0; i < 9; i++) u_host_bfm.wr(rw_a[i], 8'h31 + 8'(i));
        chk8(c1, 8'h31);
        chk8(pad, 8'h33);
        for (int i = 0; i < 2; i++) begin
            chk8(evc[i], 8'h34 + 8'(3 * i));
            chk8(evt[i], 8'h35 + 8'(3 * i));
            chk8(evd[i], 8'h36 + 8'(3 * i));
        end
        rx(ADDR_EV1_SRC, 8'h3c);
        chk1(ack1, 1'b1);
        rx(ADDR_EV2_SRC, 8'hc3);
        chk1(ack2, 1'b1);
        for (int i = 0; i < 9; i++) rx(rw_a[i], 8'h31 + 8'(i));
        u_host_bfm.wr(ADDR_STATUS, 8'hff);
        u_host_bfm.wr(ADDR_IDENTITY, 8'h00);
        rx(ADDR_IDENTITY, IDENTITY_VALUE);
        rx(ADDR_STATUS, 8'h00);
        rx(ADDR_CTRL1, 8'h31);
        foreach (rw_a[i]) if (i < 3) rx(7'h28 + 7'(2 * i), 8'h00);
        for (int c = 0; c < 4; c++) begin
            u_host_bfm.wr(ADDR_CTRL2, {6'h0e, 2'(c)});
            chk8(c2, {6'h0e, 2'(c)});
        end
        u_host_bfm.wr(ADDR_CTRL2, 8'h80);
        chk1(shared, 1'b1);
        u_host_bfm.wr(ADDR_CTRL2, 8'h00);
        chk1(shared, 1'b0);
        @(posedge clk);
        rom <= '{8'ha5, 8'h5a, 8'hc3, 8'h3c};
        u_host_bfm.wr(ADDR_CTRL2, 8'h40);
        chk1(busy, 1'b1);
        wait_boot();
        for (int i = 0; i < TRIM_N; i++) chk8(trim[i], rom[i]);
        samp('{8'h12, 8'h34, 8'h56}, r);
        chk1(r, 1'b0);
        rx(ADDR_STATUS, 8'h00);
        u_host_bfm.wr(ADDR_CTRL1, 8'h47);
        samp('{8'h12, 8'h34, 8'h56}, r);
        chk1(r, 1'b1);
        samp('{8'h9a, 8'hbc, 8'hde}, r);
        rx(ADDR_STATUS, 8'hff);
        rx(ADDR_STATUS, 8'h00);
        rx(ADDR_X, 8'h9a);
        rx(ADDR_Z, 8'hde);
        u_host_bfm.wr(ADDR_CTRL1, 8'h40);
        samp('{8'h01, 8'h02, 8'h03}, r);
        chk1(r, 1'b0);
        u_host_bfm.rd(ADDR_HP_RESET, d);
        chk1(hpc, 1'b1);
        // reset in mid-run must bring back reset values and restart the trim restore
        @(posedge clk);
        srst <= 1'b1;
        rom <= '{8'h69, 8'h96, 8'h18, 8'h81};
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        wait_boot();
        for (int i = 0; i < TRIM_N; i++) chk8(trim[i], rom[i]);
        rx(ADDR_CTRL1, RST_CTRL1);
        rx(ADDR_CTRL2, RST_ZERO);
        test_done();
    end
endmodule
